// ==== shared/itfc_pkg.sv ====
/*
 * Constants, types and states shared by the contact-input frequency control.
 * Assumes one 50 MHz clock and settings held stable by the parameter set.
 */
package itfc_pkg;

  // Widths; frequencies are in 0.1 % of maximum output frequency
  localparam int unsigned NUM_TERM = 10;
  localparam int unsigned SEL_W    = 8;
  localparam int unsigned FREQ_W   = 12;
  localparam int unsigned TIME_W   = 16;

  typedef logic [SEL_W-1:0]  itfc_sel_t;
  typedef logic [FREQ_W-1:0] itfc_freq_t;
  typedef logic [TIME_W-1:0] itfc_time_t;

  // Selector function codes
  localparam itfc_sel_t SEL_BLOCK_NO  = 8'h08;
  localparam itfc_sel_t SEL_BLOCK_NC  = 8'h09;
  localparam itfc_sel_t SEL_RAMP_HOLD = 8'h0a;
  localparam itfc_sel_t SEL_RAISE     = 8'h10;
  localparam itfc_sel_t SEL_LOWER     = 8'h11;

  // Limit range and reset values
  localparam itfc_freq_t PCT_MAX          = 12'd1100;
  localparam itfc_freq_t UPPER_RST        = 12'd1000;
  localparam itfc_freq_t LOWER_RST        = 12'd0;
  localparam itfc_freq_t MASTER_LOWER_RST = 12'd0;
  localparam itfc_freq_t FREQ_ZERO        = 12'd0;
  localparam logic       HOLD_MEM_RST     = 1'b0;
  localparam itfc_time_t STEP_CYC_RST     = 16'h0001;

  // Sequencer states, Gray along stop, run, block, search
  typedef enum logic [1:0] {
    ST_STOP   = 2'b00,
    ST_RUN    = 2'b01,
    ST_BLOCK  = 2'b11,
    ST_SEARCH = 2'b10
  } itfc_state_t;

endpackage : itfc_pkg

// ==== shared/itfc_func_if.sv ====
/*
 * Decoded contact functions passed from the selector decoder to the core.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/1ps
interface itfc_func_if;
  logic block_req;
  logic hold_on;
  logic raise_on;
  logic lower_on;
  logic hold_assigned;
  logic updown_assigned;
  logic assign_err;

  modport decoder (
    output block_req, hold_on, raise_on, lower_on,
    output hold_assigned, updown_assigned, assign_err
  );
  modport user (
    input block_req, hold_on, raise_on, lower_on,
    input hold_assigned, updown_assigned, assign_err
  );
endinterface : itfc_func_if

// ==== src/itfc_decode.sv ====
/*
 * Maps each contact terminal through its function selector.
 * Assumes terminals and selectors are synchronous and stable.
 */
`timescale 1ns/1ps
module itfc_decode #(
  parameter int unsigned NUM_TERM = itfc_pkg::NUM_TERM
) (
  input  wire itfc_pkg::itfc_sel_t [NUM_TERM-1:0] selector,
  input  wire logic [NUM_TERM-1:0]                 contact,
  itfc_func_if.decoder                             fn
);
  import itfc_pkg::*;

  logic [NUM_TERM-1:0] blk_v;
  logic [NUM_TERM-1:0] hold_v;
  logic [NUM_TERM-1:0] up_v;
  logic [NUM_TERM-1:0] dn_v;
  logic [NUM_TERM-1:0] hold_a;
  logic [NUM_TERM-1:0] up_a;
  logic [NUM_TERM-1:0] dn_a;

  // One decoder per terminal, each independent of the others
  for (genvar i = 0; i < NUM_TERM; i++) begin : g_term
    assign blk_v[i]  = (selector[i] == SEL_BLOCK_NO && contact[i])
                    || (selector[i] == SEL_BLOCK_NC && !contact[i]);
    assign hold_a[i] = (selector[i] == SEL_RAMP_HOLD);
    assign up_a[i]   = (selector[i] == SEL_RAISE);
    assign dn_a[i]   = (selector[i] == SEL_LOWER);
    assign hold_v[i] = hold_a[i] && contact[i];
    assign up_v[i]   = up_a[i] && contact[i];
    assign dn_v[i]   = dn_a[i] && contact[i];
  end

  // Reduce to function levels and assignment checks
  assign fn.block_req       = |blk_v;
  assign fn.hold_on         = |hold_v;
  assign fn.raise_on        = |up_v;
  assign fn.lower_on        = |dn_v;
  assign fn.hold_assigned   = |hold_a;
  assign fn.updown_assigned = (|up_a) && (|dn_a);
  assign fn.assign_err      = ((|up_a) != (|dn_a))
                           || (((|up_a) || (|dn_a)) && (|hold_a));

  initial begin
    if (NUM_TERM < 1 || NUM_TERM > 32)
      $error("itfc_decode: NUM_TERM out of range");
  end

endmodule : itfc_decode

// ==== src/itfc_ramp.sv ====
/*
 * Output frequency ramp: one unit per step period toward a target.
 * Assumes step periods of at least one cycle; zero is treated as one.
 */
`timescale 1ns/1ps
module itfc_ramp (
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic                load,
  input  wire itfc_pkg::itfc_freq_t load_value,
  input  wire logic                freeze,
  input  wire itfc_pkg::itfc_freq_t target,
  input  wire itfc_pkg::itfc_time_t accel_cycles,
  input  wire itfc_pkg::itfc_time_t decel_cycles,
  output logic                     at_target,
  output itfc_pkg::itfc_freq_t     freq
);
  import itfc_pkg::*;

  typedef struct packed {
    itfc_freq_t freq;
    itfc_time_t cnt;
  } itfc_ramp_st_t;

  itfc_ramp_st_t s_r;
  itfc_ramp_st_t s_nxt;
  itfc_time_t    period;

  // Next ramp value; load wins, freeze holds the value and clears the timer
  always_comb begin
    s_nxt  = s_r;
    period = (target > s_r.freq) ? accel_cycles : decel_cycles;
    if (load) begin
      s_nxt.freq = load_value;
      s_nxt.cnt  = '0;
    end else if (!freeze && target != s_r.freq) begin
      if (s_r.cnt + 16'h0001 >= period) begin
        s_nxt.cnt  = '0;
        s_nxt.freq = (target > s_r.freq) ? s_r.freq + 12'd1
                                         : s_r.freq - 12'd1;
      end else begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
      end
    end else begin
      s_nxt.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{freq: FREQ_ZERO, cnt: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign freq      = s_r.freq;
  assign at_target = (s_r.freq == target);

endmodule : itfc_ramp

// ==== src/itfc_top.sv ====
/*
 * Contact-input frequency control: output block, ramp hold with
 * retained hold frequency, raise/lower stepping within limits, and
 * input assignment checking.
 * Assumes a 50 MHz clock, synchronous contact inputs, and an external
 * non-volatile store that keeps held_reference_memory across power-off
 * and offers it back through held_reference_restore.
 */
`timescale 1ns/1ps
module itfc_top #(
  parameter int unsigned NUM_TERM = itfc_pkg::NUM_TERM
) (
  input  wire logic                                 clock,
  input  wire logic                                 resetn,
  input  wire logic [NUM_TERM-1:0]                  contact_terminal,
  input  wire itfc_pkg::itfc_sel_t [NUM_TERM-1:0]   input_function_selector,
  input  wire logic                                 hold_memory_select,
  input  wire itfc_pkg::itfc_freq_t                 reference_upper_limit,
  input  wire itfc_pkg::itfc_freq_t                 reference_lower_limit,
  input  wire itfc_pkg::itfc_freq_t                 master_reference_lower_limit,
  input  wire itfc_pkg::itfc_time_t                 accel_step_cycles,
  input  wire itfc_pkg::itfc_time_t                 decel_step_cycles,
  input  wire logic                                 run_command,
  input  wire itfc_pkg::itfc_freq_t                 frequency_reference,
  input  wire logic                                 restore_load,
  input  wire itfc_pkg::itfc_freq_t                 held_reference_restore,
  output logic                                      drive_enable,
  output logic                                      motor_coasting,
  output logic                                      speed_search_start,
  output itfc_pkg::itfc_freq_t                      speed_search_frequency,
  output itfc_pkg::itfc_freq_t                      output_frequency,
  output logic                                      frequency_agree,
  output itfc_pkg::itfc_freq_t                      held_reference_memory,
  output logic                                      hold_memory_active,
  output logic                                      multi_step_enable,
  output logic                                      invalid_input_assignment_error
);
  import itfc_pkg::*;

  // Whole control state of the core
  typedef struct packed {
    itfc_state_t state;
    logic        run_d;
    itfc_freq_t  pre_block;
    itfc_freq_t  held_mem;
    logic        search;
    logic        drive_en;
    logic        err;
  } itfc_core_st_t;

  itfc_core_st_t s_r;
  itfc_core_st_t s_nxt;

  itfc_func_if fn ();

  logic       run_ok;
  logic       run_rise;
  logic       mem_eff;
  logic       ud_used;
  logic       ramp_load;
  logic       ramp_freeze;
  itfc_freq_t ramp_load_val;
  itfc_freq_t ramp_target;
  itfc_freq_t ramp_freq;
  logic       ramp_at;
  itfc_freq_t upper_eff;
  itfc_freq_t lower_eff;
  itfc_freq_t ref_clamped;
  itfc_freq_t restart_val;

  // Terminal decoding
  itfc_decode #(
    .NUM_TERM (NUM_TERM)
  ) u_decode (
    .selector (input_function_selector),
    .contact  (contact_terminal),
    .fn       (fn)
  );

  // Output frequency ramp
  itfc_ramp u_ramp (
    .clock        (clock),
    .resetn       (resetn),
    .load         (ramp_load),
    .load_value   (ramp_load_val),
    .freeze       (ramp_freeze),
    .target       (ramp_target),
    .accel_cycles (accel_step_cycles),
    .decel_cycles (decel_step_cycles),
    .at_target    (ramp_at),
    .freq         (ramp_freq)
  );

  // Effective limits; settings above 110.0 % are capped at the range
  always_comb begin
    upper_eff = (reference_upper_limit > PCT_MAX)
              ? PCT_MAX : reference_upper_limit;
    lower_eff = (reference_lower_limit > master_reference_lower_limit)
              ? reference_lower_limit
              : master_reference_lower_limit;
    if (lower_eff > upper_eff) begin
      lower_eff = upper_eff;
    end
    ref_clamped = frequency_reference;
    if (ref_clamped > upper_eff) begin
      ref_clamped = upper_eff;
    end
    if (ref_clamped < lower_eff) begin
      ref_clamped = lower_eff;
    end
  end

  // Qualifiers derived from the decoded functions
  assign ud_used  = fn.updown_assigned && !fn.assign_err;
  assign mem_eff  = hold_memory_select
                 && (fn.hold_assigned || fn.updown_assigned);
  assign run_ok   = run_command && !fn.assign_err;
  assign run_rise = run_ok && !s_r.run_d;

  // Value to restart from on a run edge
  always_comb begin
    if (mem_eff) begin
      restart_val = s_r.held_mem;
    end else begin
      restart_val = FREQ_ZERO;
    end
    if (restart_val > upper_eff) begin
      restart_val = upper_eff;
    end
  end

  // Ramp steering: load on starts and searches, freeze on hold
  always_comb begin
    ramp_load     = 1'b0;
    ramp_load_val = FREQ_ZERO;
    ramp_freeze   = 1'b0;
    ramp_target   = FREQ_ZERO;
    case (s_r.state)
      ST_STOP: begin
        ramp_load     = 1'b1;                                // Idle at zero
        ramp_load_val = FREQ_ZERO;
        if (run_rise) begin
          ramp_load_val = restart_val;
          if (fn.hold_on && !mem_eff) begin
            ramp_load_val = FREQ_ZERO;
          end
        end
      end
      ST_RUN: begin
        if (ud_used) begin
          // Raise/lower drives the target to a limit or holds in place
          if (fn.raise_on && !fn.lower_on) begin
            ramp_target = upper_eff;
          end else if (fn.lower_on && !fn.raise_on) begin
            ramp_target = lower_eff;
          end else if (ramp_freq < lower_eff) begin
            ramp_target = lower_eff;
          end else if (ramp_freq > upper_eff) begin
            ramp_target = upper_eff;
          end else begin
            ramp_target = ramp_freq;
          end
        end else begin
          ramp_target = ref_clamped;
          ramp_freeze = fn.hold_on;
        end
      end
      ST_BLOCK: begin
        ramp_load     = 1'b1;                                // No drive
        ramp_load_val = FREQ_ZERO;
      end
      ST_SEARCH: begin
        ramp_load     = 1'b1;
        ramp_load_val = s_r.pre_block;
      end
      default: begin
        ramp_load     = 1'b1;
        ramp_load_val = FREQ_ZERO;
      end
    endcase
  end

  // Sequencer and held-frequency memory
  always_comb begin
    s_nxt        = s_r;
    s_nxt.run_d  = run_ok;
    s_nxt.search = 1'b0;
    s_nxt.err    = fn.assign_err;
    case (s_r.state)
      ST_STOP: begin
        s_nxt.drive_en = 1'b0;
        if (run_rise && !fn.block_req) begin
          s_nxt.state    = ST_RUN;
          s_nxt.drive_en = 1'b1;
        end
      end
      ST_RUN: begin
        s_nxt.drive_en = 1'b1;
        if (!run_ok) begin
          s_nxt.state    = ST_STOP;
          s_nxt.drive_en = 1'b0;
        end else if (fn.block_req) begin
          s_nxt.state     = ST_BLOCK;
          s_nxt.drive_en  = 1'b0;
          s_nxt.pre_block = ramp_freq;
        end
      end
      ST_BLOCK: begin
        s_nxt.drive_en = 1'b0;
        if (!run_ok) begin
          s_nxt.state = ST_STOP;
        end else if (!fn.block_req) begin
          s_nxt.state    = ST_SEARCH;
          s_nxt.search   = 1'b1;
          s_nxt.drive_en = 1'b1;
        end
      end
      ST_SEARCH: begin
        s_nxt.drive_en = 1'b1;
        s_nxt.state    = ST_RUN;
        if (!run_ok) begin
          s_nxt.state    = ST_STOP;
          s_nxt.drive_en = 1'b0;
        end
      end
      default: begin
        s_nxt.state    = ST_STOP;
        s_nxt.drive_en = 1'b0;
      end
    endcase
    // Retained frequency: latch on hold, follow raise/lower while running
    if (restore_load) begin
      s_nxt.held_mem = held_reference_restore;
    end else if (mem_eff && s_r.state == ST_RUN) begin
      if (fn.hold_on && !fn.updown_assigned) begin
        s_nxt.held_mem = ramp_freq;
      end else if (ud_used) begin
        s_nxt.held_mem = ramp_freq;
      end
    end
  end

  // Core state register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{state:     ST_STOP,
               run_d:     1'b0,
               pre_block: FREQ_ZERO,
               held_mem:  FREQ_ZERO,
               search:    1'b0,
               drive_en:  1'b0,
               err:       1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Output drive
  assign drive_enable                   = s_r.drive_en;
  assign motor_coasting                 = (s_r.state == ST_BLOCK);
  assign speed_search_start             = s_r.search;
  assign speed_search_frequency         = s_r.pre_block;
  assign output_frequency               = s_r.drive_en ? ramp_freq
                                                       : FREQ_ZERO;
  assign frequency_agree                = s_r.drive_en && ramp_at;
  assign held_reference_memory          = s_r.held_mem;
  assign hold_memory_active             = mem_eff;
  assign multi_step_enable              = !ud_used;
  assign invalid_input_assignment_error = s_r.err;

  initial begin
    if (NUM_TERM < 1 || NUM_TERM > 32)
      $error("itfc_top: NUM_TERM out of range");
  end

endmodule : itfc_top

// ==== sim/itfc_contacts.sv ====
/*
 * Model of the external switches or controller on the contact terminals.
 * Assumes the bench calls its tasks; every change lands just after an edge.
 */
`timescale 1ns/1ps
module itfc_contacts #(
  parameter int unsigned NUM_TERM = 10
) (
  input  wire logic          clock,
  output logic [NUM_TERM-1:0] contact_terminal,
  output logic               run_command
);
  // All contacts open and no run at power-up
  initial begin
    contact_terminal = '0;
    run_command      = 1'b0;
  end

  // Close or open one terminal just after the next rising edge
  task automatic set_contact(input int idx, input logic lvl);
    @(posedge clock);
    #1 contact_terminal[idx] = lvl;
  endtask : set_contact

  // Run comes from the control terminals, changed just after the next rising edge
  task automatic set_run(input logic lvl);
    @(posedge clock);
    #1 run_command = lvl;
  endtask : set_run
endmodule : itfc_contacts

// ==== sim/itfc_assertions.sv ====
/*
 * Concurrent checks on the contact-input frequency control.
 * Assumes it is bound to itfc_top and sees only its ports.
 */
`timescale 1ns/1ps
module itfc_assertions #(
  parameter int unsigned NUM_TERM = 10
) (
  input wire logic                                clock,
  input wire logic                                resetn,
  input wire logic [NUM_TERM-1:0]                 contact_terminal,
  input wire itfc_pkg::itfc_sel_t [NUM_TERM-1:0]  input_function_selector,
  input wire logic                                hold_memory_select,
  input wire itfc_pkg::itfc_freq_t                reference_upper_limit,
  input wire logic                                run_command,
  input wire logic                                drive_enable,
  input wire logic                                motor_coasting,
  input wire logic                                speed_search_start,
  input wire itfc_pkg::itfc_freq_t                speed_search_frequency,
  input wire itfc_pkg::itfc_freq_t                output_frequency,
  input wire logic                                hold_memory_active,
  input wire logic                                multi_step_enable,
  input wire logic                                invalid_input_assignment_error
);
  import itfc_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  logic blk_in, hold_asg, hold_in, up_asg, dn_asg, bad;

  // Own decode of the selectors, terminal by terminal
  always_comb begin
    {blk_in, hold_asg, hold_in, up_asg, dn_asg} = '0;
    for (int i = 0; i < NUM_TERM; i++) begin
      blk_in |= (input_function_selector[i] == SEL_BLOCK_NO &&
                 contact_terminal[i]) ||
                (input_function_selector[i] == SEL_BLOCK_NC &&
                 !contact_terminal[i]);
      hold_asg |= input_function_selector[i] == SEL_RAMP_HOLD;
      hold_in |= input_function_selector[i] == SEL_RAMP_HOLD &&
                 contact_terminal[i];
      up_asg |= input_function_selector[i] == SEL_RAISE;
      dn_asg |= input_function_selector[i] == SEL_LOWER;
    end
    bad = (up_asg ^ dn_asg) || ((up_asg || dn_asg) && hold_asg);
  end

  // Search pulse: one cycle, straight out of the block state
  sequence s_pulse;
    speed_search_start && drive_enable ##1 !speed_search_start;
  endsequence

  block_entry_a: assert property (drive_enable && blk_in && run_command &&
    !speed_search_start && !invalid_input_assignment_error
    |=> motor_coasting && !drive_enable) else $error("block not taken");
  coast_gate_a: assert property (motor_coasting |-> !drive_enable &&
    output_frequency == 12'h000) else $error("drive during block");
  search_pulse_a: assert property (speed_search_start |->
    $past(motor_coasting) ##0 s_pulse) else $error("bad search pulse");
  search_freq_a: assert property (speed_search_start |=>
    output_frequency == $past(speed_search_frequency))
    else $error("search not from saved frequency");
  upper_cap_a: assert property (drive_enable &&
    reference_upper_limit <= PCT_MAX |->
    output_frequency <= reference_upper_limit) else $error("above upper");
  hold_freeze_a: assert property (drive_enable && $past(drive_enable) &&
    $past(hold_in) && !$past(speed_search_start) && !up_asg && !dn_asg
    |-> $stable(output_frequency)) else $error("ramp moved in hold");
  err_flag_a: assert property ($past(resetn) |->
    invalid_input_assignment_error == $past(bad))
    else $error("assignment error wrong");
  err_stop_a: assert property (invalid_input_assignment_error [*2] |->
    !drive_enable) else $error("running with bad assignment");
  hold_mem_a: assert property (hold_memory_active == (hold_memory_select &&
    (hold_asg || (up_asg && dn_asg)))) else $error("memory enable wrong");
  multi_step_a: assert property (up_asg && dn_asg && !hold_asg |->
    !multi_step_enable) else $error("multi-step not disabled");
endmodule : itfc_assertions

bind itfc_top itfc_assertions #(.NUM_TERM(NUM_TERM)) itfc_assertions_inst (.*);

// ==== sim/testbench.sv ====
/*
 * Self-checking bench for the contact-input frequency control.
 * Assumes the contact model drives terminals and run; the rest is here.
 */
`timescale 1ns/1ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  failures++; $display("mismatch at %0t: got %0h expected %0h", \
  $time, got, exp); end end
module testbench;
  import itfc_pkg::*;
  logic                 clock = 1'b0;
  logic                 resetn;
  logic [9:0]           contact_terminal;
  logic                 run_command;
  itfc_sel_t [9:0]      sel;
  logic                 mem_sel;
  logic                 restore_load;
  itfc_freq_t           upper;
  itfc_freq_t           lower;
  itfc_freq_t           mlower;
  itfc_freq_t           freq_ref;
  itfc_freq_t           restore_val;
  itfc_time_t           acc;
  itfc_time_t           dec;
  logic                 drive, coast, search, agree, mem_act, mstep, err;
  itfc_freq_t           search_freq, out_freq, held;
  int                   failures = 0;
  int                   cmp_count = 0;
  int                   cyc;

  // Clock at 50 MHz
  always #10 clock = ~clock;

  itfc_contacts #(.NUM_TERM(10)) itfc_contacts_inst (
    .clock(clock), .contact_terminal(contact_terminal),
    .run_command(run_command));

  itfc_top #(.NUM_TERM(10)) itfc_top_inst (
    .clock(clock), .resetn(resetn), .contact_terminal(contact_terminal),
    .input_function_selector(sel), .hold_memory_select(mem_sel),
    .reference_upper_limit(upper), .reference_lower_limit(lower),
    .master_reference_lower_limit(mlower), .accel_step_cycles(acc),
    .decel_step_cycles(dec), .run_command(run_command),
    .frequency_reference(freq_ref), .restore_load(restore_load),
    .held_reference_restore(restore_val), .drive_enable(drive),
    .motor_coasting(coast), .speed_search_start(search),
    .speed_search_frequency(search_freq), .output_frequency(out_freq),
    .frequency_agree(agree), .held_reference_memory(held),
    .hold_memory_active(mem_act), .multi_step_enable(mstep),
    .invalid_input_assignment_error(err));

  // Advance n edges and land just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  // Bounded wait for an output frequency, cycles kept in cyc
  task automatic wait_freq(input itfc_freq_t v);
    cyc = 0;
    while (out_freq !== v && cyc < 2000) begin
      step(1);
      cyc++;
    end
    `CHECK(out_freq, v)
  endtask : wait_freq

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  // Hang guard at 20000 cycles, well past the fewer than a thousand cycles of the tests
  initial begin
    #400000;
    failures++;
    give_verdict();
  end

  initial begin
    // Power-up settings, held in reset
    resetn = 1'b0;
    sel = '0;
    mem_sel = 1'b0;
    restore_load = 1'b0;
    upper = 12'h028;
    lower = 12'h000;
    mlower = 12'h000;
    freq_ref = 12'h01e;
    restore_val = 12'h000;
    acc = 16'h0010;
    dec = 16'h0004;
    sel[0] = SEL_BLOCK_NO;
    sel[1] = SEL_BLOCK_NC;
    sel[2] = SEL_RAMP_HOLD;
    itfc_contacts_inst.set_contact(1, 1'b1);
    step(4);
    resetn = 1'b1;
    step(1);
    `CHECK(mem_act, 1'b0)
    `CHECK(mstep, 1'b1)
    mem_sel = 1'b1;
    // Ramp hold freezes and memorises the running frequency
    itfc_contacts_inst.set_run(1'b1);
    step(1);
    `CHECK(drive, 1'b1)
    `CHECK(mem_act, 1'b1)
    wait_freq(12'h00c);
    itfc_contacts_inst.set_contact(2, 1'b1);
    step(20);
    `CHECK(out_freq, 12'h00c)
    `CHECK(held, 12'h00c)
    itfc_contacts_inst.set_contact(2, 1'b0);
    wait_freq(12'h01e);
    `CHECK(agree, 1'b1)
    // Normally open, then normally closed block with a new reference
    for (int k = 0; k < 2; k++) begin
      freq_ref = 12'h01e;
      wait_freq(12'h01e);
      itfc_contacts_inst.set_contact(k, k == 0);
      freq_ref = 12'h00a;
      step(1);
      `CHECK(coast, 1'b1)
      `CHECK({drive, out_freq}, 13'h0000)
      `CHECK(search_freq, 12'h01e)
      itfc_contacts_inst.set_contact(k, k != 0);
      cyc = 0;
      while (search !== 1'b1 && cyc < 10) begin
        step(1);
        cyc++;
      end
      `CHECK(search, 1'b1)
      step(1);
      `CHECK(out_freq, 12'h01e)
    end
    // Restart with hold on: held value, then zero without memory
    itfc_contacts_inst.set_run(1'b0);
    itfc_contacts_inst.set_contact(2, 1'b1);
    itfc_contacts_inst.set_run(1'b1);
    step(1);
    `CHECK(out_freq, 12'h00c)
    mem_sel = 1'b0;
    itfc_contacts_inst.set_run(1'b0);
    itfc_contacts_inst.set_run(1'b1);
    step(1);
    `CHECK({drive, out_freq}, 13'h1000)
    // Power cycle, then restore the retained value
    itfc_contacts_inst.set_run(1'b0);
    resetn = 1'b0;
    step(2);
    `CHECK(held, 12'h000)
    resetn = 1'b1;
    restore_load = 1'b1;
    restore_val = 12'h019;
    step(1);
    restore_load = 1'b0;
    mem_sel = 1'b1;
    itfc_contacts_inst.set_run(1'b1);
    step(1);
    `CHECK(out_freq, 12'h019)
    // Assignment errors refuse running
    itfc_contacts_inst.set_run(1'b0);
    itfc_contacts_inst.set_contact(2, 1'b0);
    mem_sel = 1'b0;
    sel[2] = 8'h00;
    sel[3] = SEL_RAISE;
    step(2);
    `CHECK(err, 1'b1)
    itfc_contacts_inst.set_run(1'b1);
    step(2);
    `CHECK(drive, 1'b0)
    itfc_contacts_inst.set_run(1'b0);
    sel[2] = SEL_RAMP_HOLD;
    sel[4] = SEL_LOWER;
    step(2);
    `CHECK(err, 1'b1)
    sel[2] = 8'h00;
    step(2);
    `CHECK({err, mstep}, 2'b00)
    // Raise and lower between the limits
    lower = 12'h005;
    upper = 12'h024;
    acc = 16'h0004;
    dec = 16'h0002;
    itfc_contacts_inst.set_run(1'b1);
    wait_freq(12'h005);
    step(20);
    `CHECK(out_freq, 12'h005)
    itfc_contacts_inst.set_contact(3, 1'b1);
    wait_freq(12'h024);
    `CHECK(cyc inside {[120:132]}, 1'b1)
    itfc_contacts_inst.set_contact(4, 1'b1);
    step(20);
    `CHECK(out_freq, 12'h024)
    itfc_contacts_inst.set_contact(3, 1'b0);
    wait_freq(12'h005);
    `CHECK(cyc inside {[60:66]}, 1'b1)
    mlower = 12'h008;
    wait_freq(12'h008);
    give_verdict();
  end
endmodule : testbench
